//--- common/nmr_map.vh
// Contract
// - Mode five offered only together with rate adaptation.
// - Mode five demands fast message rate both ways.
// - Reference noise is max of external, virtual.
// - Virtual noise is channel gain times profile.
// - Office sets profiles; downstream sent in signature.
// - Showtime profile revisions arrive by update command.
// - Changed profile triggers rate adaptation when needed.
// - Profile values stay within lower and upper limits.
// - Margin over loaded subcarriers, robust channel excluded.
// - Modes two to five include virtual noise.
// - Measure at init; refresh autonomously or on request.
// - Send margin far end at init, diagnostics.
// - Forward margin to far end on its request.
// - Margin is 10-bit signed, tenths of dB.
// - Code -512 means out of range or unmeasured.
// - Upstream margin uses identical definition and encoding.
`ifndef NMR_MAP_VH
`define NMR_MAP_VH
`define NMR_OFF_CTRL    5'h00
`define NMR_OFF_MRG_DS  5'h04
`define NMR_OFF_MRG_US  5'h08
`define NMR_OFF_LIM_DS  5'h0C
`define NMR_OFF_LIM_US  5'h10
`define NMR_OFF_IRQ_ST  5'h14
`define NMR_OFF_IRQ_MSK 5'h18
`define NMR_OFF_CAP     5'h1C
`define NMR_CTRL_MDS_LSB 0
`define NMR_CTRL_MUS_LSB 3
`define NMR_CTRL_AUTO    6
`define NMR_CTRL_REQ_DS  8
`define NMR_CTRL_REQ_US  9
`define NMR_LIM_HI_LSB   16
`define NMR_MODE_RST     3'h1
`define NMR_MODE_SHOWTIME_ADAPTIVE_VIRTUAL_NOISE    3'h5
`define NMR_LIM_LO_RST   10'h2D4
`define NMR_LIM_HI_RST   10'h3D2
`define NMR_SRA_CAP      1'h1
`define NMR_MRG_SPECIAL  10'h200
`define NMR_MRG_RST      10'h200
`define NMR_PH_INIT      2'h1
`define NMR_PH_SHOW      2'h2
`define NMR_PH_DIAG      2'h3
`define NMR_ST_MEAS_DS   0
`define NMR_ST_MEAS_US   1
`define NMR_ST_RA        2
`define NMR_ST_CLAMP     3
`endif

//--- rtl/nmr_core.v
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "nmr_map.vh"
module nmr_core (
  input  wire        mclk,
  input  wire        rst,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire [1:0]  linePhase,
  input  wire        scValid,
  input  wire        scDir,
  input  wire [5:0]  scIdx,
  input  wire        scLoaded,
  input  wire        scRoc,
  input  wire [9:0]  scExt,
  input  wire [9:0]  scH2,
  input  wire [9:0]  scSig,
  input  wire [9:0]  scReq,
  input  wire [9:0]  scVn,
  input  wire        scLast,
  input  wire        profValid,
  input  wire        profUpdate,
  input  wire        profDir,
  input  wire [5:0]  profIdx,
  input  wire [9:0]  profVal,
  input  wire        profEnd,
  input  wire        farReq,
  input  wire        farReqDir,
  output reg         farValid,
  output reg         farDir,
  output reg  [9:0]  farMargin,
  output reg         raReq,
  output reg         raDir,
  output reg         msgRateFast,
  output reg         irq
);

  // Limits a profile code to the signed window lo..hi.
  function [9:0] clampLim;
    input [9:0] v;
    input [9:0] lo;
    input [9:0] hi;
    begin
      if ($signed(v) < $signed(lo))
        clampLim = lo;
      else if ($signed(v) > $signed(hi))
        clampLim = hi;
      else
        clampLim = v;
    end
  endfunction

  // Maps an unsupported mode code onto the mandatory mode.
  function [2:0] legalMode;
    input [2:0] m;
    begin
      if (m == 3'h0 || m > `NMR_MODE_SHOWTIME_ADAPTIVE_VIRTUAL_NOISE)
        legalMode = `NMR_MODE_RST;
      else if (m == `NMR_MODE_SHOWTIME_ADAPTIVE_VIRTUAL_NOISE && !`NMR_SRA_CAP)
        legalMode = `NMR_MODE_RST;
      else
        legalMode = m;
    end
  endfunction

  // Sweep accumulator start value and the largest codable margin.
  localparam signed [15:0] ACC_INIT = 16'sh7FFF;
  localparam signed [15:0] MRG_MAX  = 16'sh01FF;

  // State per direction, status and the profile store.
  reg  [2:0]  modeQ [0:1];
  reg         autoRef_q;
  reg  [1:0]  reqPend_q;
  reg  [9:0]  limLo_q [0:1];
  reg  [9:0]  limHi_q [0:1];
  reg  [9:0]  margin_q [0:1];
  reg  [3:0]  stat_q;
  reg  [3:0]  mask_q;
  reg  [3:0]  stat_d;
  reg  [15:0] minAcc_q [0:1];
  reg  [1:0]  anyLoaded_q;
  reg  [1:0]  chg_q;
  reg         farPend_q;
  reg         farPendDir_q;
  reg  [9:0]  profMem [0:127];
  reg  [31:0] rdMux;

  // Bus handshake qualifiers and line phase decodes.
  wire        busAcc = (avs_read | avs_write) & ~avs_waitrequest;
  wire        busWr  = avs_write & ~avs_waitrequest;
  wire        busRd  = avs_read & ~avs_waitrequest;
  wire        stRead = busRd & (avs_address == `NMR_OFF_IRQ_ST);
  wire        isDiag = (linePhase == `NMR_PH_DIAG);
  wire        isInit = (linePhase == `NMR_PH_INIT);
  wire        isShow = (linePhase == `NMR_PH_SHOW);

  // Per-subcarrier margin in the log domain, half-dB units.
  wire [2:0]  curMode = modeQ[scDir];
  wire [9:0]  profUse = clampLim(profMem[{scDir, scIdx}],
                                 limLo_q[scDir], limHi_q[scDir]);
  wire signed [12:0] extS = {{3{scExt[9]}}, scExt};
  wire signed [12:0] h2pS = {{3{scH2[9]}}, scH2} +
                            {{3{profUse[9]}}, profUse};
  wire signed [12:0] vnS  = {{3{scVn[9]}}, scVn};
  reg  signed [12:0] refS;
  always @* begin
    refS = extS;
    if (curMode == `NMR_MODE_SHOWTIME_ADAPTIVE_VIRTUAL_NOISE && h2pS > extS)
      refS = h2pS;
    else if (curMode != `NMR_MODE_SHOWTIME_ADAPTIVE_VIRTUAL_NOISE && curMode > 3'h1 && vnS > extS)
      refS = vnS;
  end
  wire signed [12:0] mHalf = {{3{scSig[9]}}, scSig} - refS -
                             {{3{scReq[9]}}, scReq};
  wire signed [15:0] mTenth = {{3{mHalf[12]}}, mHalf} * 16'sh0005;

  // Running minimum including the current subcarrier when it counts.
  wire        counts = scValid & scLoaded & ~scRoc;
  wire signed [15:0] accS = minAcc_q[scDir];
  wire signed [15:0] curMin = (counts && mTenth < accS) ? mTenth : accS;
  wire        curAny = anyLoaded_q[scDir] | counts;
  wire        measEn = isInit | isDiag |
                       (isShow & (autoRef_q | reqPend_q[scDir]));
  reg  [9:0]  code;
  always @* begin
    code = curMin[9:0];
    if (isDiag || !curAny || curMin > MRG_MAX || curMin < -MRG_MAX)
      code = `NMR_MRG_SPECIAL;
  end
  wire        measDone = scValid & scLast & measEn;

  // Profile load acceptance: signature at init, update in showtime.
  wire        profOk  = profValid & (profUpdate ? isShow : isInit);
  wire [9:0]  profNew = clampLim(profVal, limLo_q[profDir],
                                 limHi_q[profDir]);
  wire [9:0]  profOld = profMem[{profDir, profIdx}];
  wire        chgNow  = profOk & profUpdate & (profNew != profOld);
  wire        raFire  = profEnd & profUpdate & isShow &
                        (chg_q[profDir] | chgNow) &
                        (modeQ[profDir] == `NMR_MODE_SHOWTIME_ADAPTIVE_VIRTUAL_NOISE);

  // Profile storage has no reset; it is always loaded before use.
  always @(posedge mclk) begin
    if (profOk)
      profMem[{profDir, profIdx}] <= profNew;
  end

  // Read data selection, captured while waitrequest is still high.
  always @* begin
    rdMux = 32'h00000000;
    case (avs_address)
      `NMR_OFF_CTRL: begin
        rdMux[`NMR_CTRL_MDS_LSB+2:`NMR_CTRL_MDS_LSB] = modeQ[0];
        rdMux[`NMR_CTRL_MUS_LSB+2:`NMR_CTRL_MUS_LSB] = modeQ[1];
        rdMux[`NMR_CTRL_AUTO] = autoRef_q;
        rdMux[`NMR_CTRL_REQ_US:`NMR_CTRL_REQ_DS] = reqPend_q;
      end
      `NMR_OFF_MRG_DS: rdMux[9:0] = margin_q[0];
      `NMR_OFF_MRG_US: rdMux[9:0] = margin_q[1];
      `NMR_OFF_LIM_DS: begin
        rdMux[9:0] = limLo_q[0];
        rdMux[`NMR_LIM_HI_LSB+9:`NMR_LIM_HI_LSB] = limHi_q[0];
      end
      `NMR_OFF_LIM_US: begin
        rdMux[9:0] = limLo_q[1];
        rdMux[`NMR_LIM_HI_LSB+9:`NMR_LIM_HI_LSB] = limHi_q[1];
      end
      `NMR_OFF_IRQ_ST:  rdMux[3:0] = stat_q;
      `NMR_OFF_IRQ_MSK: rdMux[3:0] = mask_q;
      `NMR_OFF_CAP: begin
        rdMux[0] = `NMR_SRA_CAP;
        rdMux[1] = `NMR_SRA_CAP;
      end
      default: rdMux = 32'h00000000;
    endcase
  end

  // Sticky status: a read clears only the bits that it returned.
  always @* begin
    stat_d = stat_q;
    if (stRead)
      stat_d = stat_q & ~avs_readdata[3:0];
    if (measDone && !scDir)
      stat_d[`NMR_ST_MEAS_DS] = 1'b1;
    if (measDone && scDir)
      stat_d[`NMR_ST_MEAS_US] = 1'b1;
    if (raFire)
      stat_d[`NMR_ST_RA] = 1'b1;
    if (profOk && profNew != profVal)
      stat_d[`NMR_ST_CLAMP] = 1'b1;
  end

  // Avalon slave: one wait state, then the access completes.
  always @(posedge mclk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if (busAcc) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read | avs_write) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rdMux : 32'h00000000;
    end
  end

  // Configuration registers and request tracking.
  always @(posedge mclk) begin
    if (rst) begin
      modeQ[0]   <= `NMR_MODE_RST;
      modeQ[1]   <= `NMR_MODE_RST;
      autoRef_q  <= 1'b0;
      reqPend_q  <= 2'h0;
      limLo_q[0] <= `NMR_LIM_LO_RST;
      limLo_q[1] <= `NMR_LIM_LO_RST;
      limHi_q[0] <= `NMR_LIM_HI_RST;
      limHi_q[1] <= `NMR_LIM_HI_RST;
      mask_q     <= 4'h0;
      stat_q     <= 4'h0;
    end else begin
      stat_q <= stat_d;
      if (measDone)
        reqPend_q[scDir] <= 1'b0;
      if (busWr) begin
        case (avs_address)
          `NMR_OFF_CTRL: begin
            modeQ[0] <= legalMode(
              avs_writedata[`NMR_CTRL_MDS_LSB+2:`NMR_CTRL_MDS_LSB]);
            modeQ[1] <= legalMode(
              avs_writedata[`NMR_CTRL_MUS_LSB+2:`NMR_CTRL_MUS_LSB]);
            autoRef_q <= avs_writedata[`NMR_CTRL_AUTO];
            if (avs_writedata[`NMR_CTRL_REQ_DS])
              reqPend_q[0] <= 1'b1;
            if (avs_writedata[`NMR_CTRL_REQ_US])
              reqPend_q[1] <= 1'b1;
          end
          `NMR_OFF_LIM_DS: begin
            limLo_q[0] <= avs_writedata[9:0];
            limHi_q[0] <= avs_writedata[`NMR_LIM_HI_LSB+9:`NMR_LIM_HI_LSB];
          end
          `NMR_OFF_LIM_US: begin
            limLo_q[1] <= avs_writedata[9:0];
            limHi_q[1] <= avs_writedata[`NMR_LIM_HI_LSB+9:`NMR_LIM_HI_LSB];
          end
          `NMR_OFF_IRQ_MSK: mask_q <= avs_writedata[3:0];
          default: mask_q <= mask_q;
        endcase
      end
    end
  end

  // Margin sweep accumulation and result capture.
  always @(posedge mclk) begin
    if (rst) begin
      minAcc_q[0] <= ACC_INIT;
      minAcc_q[1] <= ACC_INIT;
      anyLoaded_q <= 2'h0;
      margin_q[0] <= `NMR_MRG_RST;
      margin_q[1] <= `NMR_MRG_RST;
    end else if (scValid) begin
      if (scLast) begin
        minAcc_q[scDir]    <= ACC_INIT;
        anyLoaded_q[scDir] <= 1'b0;
        if (measEn)
          margin_q[scDir] <= code;
      end else begin
        minAcc_q[scDir]    <= curMin;
        anyLoaded_q[scDir] <= curAny;
      end
    end
  end

  // Far-end reporting; a fresh measurement takes the slot first.
  always @(posedge mclk) begin
    if (rst) begin
      farValid     <= 1'b0;
      farDir       <= 1'b0;
      farMargin    <= `NMR_MRG_RST;
      farPend_q    <= 1'b0;
      farPendDir_q <= 1'b0;
    end else begin
      farValid <= 1'b0;
      if (farReq && isShow) begin
        farPend_q    <= 1'b1;
        farPendDir_q <= farReqDir;
      end
      if (measDone && (isInit || isDiag)) begin
        farValid  <= 1'b1;
        farDir    <= scDir;
        farMargin <= code;
      end else if (farPend_q) begin
        farValid  <= 1'b1;
        farDir    <= farPendDir_q;
        farMargin <= margin_q[farPendDir_q];
        farPend_q <= farReq & isShow;
      end
    end
  end

  // Profile change tracking and rate adaptation trigger.
  always @(posedge mclk) begin
    if (rst) begin
      chg_q <= 2'h0;
      raReq <= 1'b0;
      raDir <= 1'b0;
    end else begin
      raReq <= 1'b0;
      if (chgNow)
        chg_q[profDir] <= 1'b1;
      if (profEnd) begin
        chg_q[profDir] <= 1'b0;
        if (raFire) begin
          raReq <= 1'b1;
          raDir <= profDir;
        end
      end
    end
  end

  // Message rate demand follows mode five in either direction.
  always @(posedge mclk) begin
    if (rst) begin
      msgRateFast <= 1'b0;
    end else begin
      msgRateFast <= (modeQ[0] == `NMR_MODE_SHOWTIME_ADAPTIVE_VIRTUAL_NOISE) |
                     (modeQ[1] == `NMR_MODE_SHOWTIME_ADAPTIVE_VIRTUAL_NOISE);
    end
  end

  // Masked interrupt level, one cycle behind the status events.
  always @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_d & mask_q);
    end
  end

endmodule // nmr_core

//--- test/nmr_core_sva.sv
`timescale 1ns/1ps
`include "nmr_map.vh"
module nmr_core_chk (
  input logic        mclk,
  input logic        rst,
  input logic [4:0]  avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_writedata,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  input logic [1:0]  linePhase,
  input logic        scValid,
  input logic        scDir,
  input logic        scLast,
  input logic        profUpdate,
  input logic        profDir,
  input logic        profEnd,
  input logic        farReq,
  input logic        farValid,
  input logic        farDir,
  input logic [9:0]  farMargin,
  input logic        raReq,
  input logic        raDir,
  input logic        msgRateFast
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // A control write with the given mode fields, accepted by the slave.
  sequence s_ctl_wr(logic [5:0] md);
    avs_write && avs_waitrequest && avs_address == `NMR_OFF_CTRL &&
      avs_writedata[5:0] == md ##1 !avs_waitrequest;
  endsequence
  // The last subcarrier of a sweep taken in the given line phase.
  sequence s_sweep_end(logic [1:0] ph);
    scValid && scLast && linePhase == ph;
  endsequence
  AST_MSG_FAST: assert property (s_ctl_wr(6'h0D) |-> ##[0:2] msgRateFast)
    else $error("fast message rate not raised for mode five");
  AST_MSG_SLOW: assert property (s_ctl_wr(6'h09) |-> ##[1:3] !msgRateFast)
    else $error("fast message rate kept without mode five");
  AST_INIT_REPORT: assert property (s_sweep_end(`NMR_PH_INIT) |=> farValid && farDir == $past(scDir))
    else $error("init margin not reported to far end");
  AST_DIAG_SPECIAL: assert property (s_sweep_end(`NMR_PH_DIAG) |=> farValid && farMargin == `NMR_MRG_SPECIAL)
    else $error("diagnostic report lacks the special code");
  AST_FAR_SHOW: assert property (farReq && linePhase == `NMR_PH_SHOW |-> ##[1:3] farValid)
    else $error("far request not answered");
  AST_FAR_CAUSE: assert property (farValid && linePhase == `NMR_PH_SHOW |-> $past(farReq) || $past(farReq, 2) || $past(farReq, 3))
    else $error("showtime report without far request");
  AST_RA_CAUSE: assert property (raReq |-> $past(profEnd && profUpdate) && raDir == $past(profDir))
    else $error("rate adaptation without update batch");
  AST_RA_PULSE: assert property (raReq |=> !raReq)
    else $error("rate adaptation request longer than a pulse");
  AST_CAP: assert property (avs_read && avs_waitrequest && avs_address == `NMR_OFF_CAP |=> avs_readdata[1:0] == 2'h3)
    else $error("mode five offered without rate adaptation");
endmodule // nmr_core_chk

bind nmr_core nmr_core_chk i_chk (.mclk, .rst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .linePhase,
  .scValid, .scDir, .scLast, .profUpdate, .profDir, .profEnd, .farReq,
  .farValid, .farDir, .farMargin, .raReq, .raDir, .msgRateFast);

//--- test/nmr_peer.sv
`timescale 1ns/1ps
module nmr_peer (
  input  logic       mclk,
  output logic       profValid,
  output logic       profUpdate,
  output logic       profDir,
  output logic [5:0] profIdx,
  output logic [9:0] profVal,
  output logic       profEnd,
  output logic       farReq,
  output logic       farReqDir
);
  // The peer starts silent.
  initial begin
    {profValid, profUpdate, profDir, profIdx, profVal, profEnd} = '0;
    {farReq, farReqDir} = '0;
  end
  // Sends a four-entry profile batch, signature or update, then ends it.
  task send(input logic upd, input logic dir, input logic [9:0] val);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      profValid <= 1'h1;
      profUpdate <= upd;
      profDir <= dir;
      profIdx <= i[5:0];
      profVal <= val;
    end
    @(posedge mclk);
    profValid <= 1'h0;
    profVal <= ~val;
    profEnd <= 1'h1;
    @(posedge mclk);
    profEnd <= 1'h0;
  endtask
  // Asks for the margin of one direction with a single pulse.
  task ask(input logic dir);
    @(posedge mclk);
    farReq <= 1'h1;
    farReqDir <= dir;
    @(posedge mclk);
    farReq <= 1'h0;
  endtask
endmodule // nmr_peer

//--- test/nmr_core_tb.sv
`timescale 1ns/1ps
`include "nmr_map.vh"
module nmr_core_tb;
  logic        mclk, rst, avs_read, avs_write, scValid, scDir, scLoaded;
  logic        scRoc, scLast, farValid, farDir, raReq, raDir, irq;
  logic        avs_waitrequest, profValid, profUpdate, profDir, profEnd;
  logic        farReq, farReqDir, msgRateFast;
  logic [1:0]  linePhase;
  logic [4:0]  avs_address;
  logic [5:0]  scIdx, profIdx;
  logic [9:0]  scExt, scH2, scSig, scReq, scVn, profVal, farMargin, c, cds;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [10:0] fq[$];
  int          n_errors, n_tests, prof, vnOn, nRa;

  nmr_core i_dut (.mclk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .linePhase, .scValid,
    .scDir, .scIdx, .scLoaded, .scRoc, .scExt, .scH2, .scSig, .scReq, .scVn,
    .scLast, .profValid, .profUpdate, .profDir, .profIdx, .profVal, .profEnd,
    .farReq, .farReqDir, .farValid, .farDir, .farMargin, .raReq, .raDir,
    .msgRateFast, .irq);
  nmr_peer i_peer (.mclk, .profValid, .profUpdate, .profDir, .profIdx,
    .profVal, .profEnd, .farReq, .farReqDir);

  // Prints the counts and the verdict, then stops.
  task end_of_test();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Counts one comparison and reports a difference.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus access, held until waitrequest is sampled low.
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int g;
    g = 0;
    @(posedge mclk);
    {avs_read, avs_write} <= {!wr, wr};
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      g++;
    end while (avs_waitrequest !== 1'h0 && g < 20);
    if (g >= 20) begin
      n_errors++;
      end_of_test();
    end
    rd = avs_readdata;
    {avs_read, avs_write} <= 2'h0;
  endtask
  // Four-carrier sweep; carrier 1 is on the robust channel, 2 is unloaded.
  task sweep(input logic dir, input int big, output logic [9:0] code);
    int s, x, h, r, m, mn, v;
    mn = 9999;
    for (int i = 0; i < 4; i++) begin
      s = (big || i == 1 || i == 2) ? -300 : int'($urandom_range(20)) - 70;
      x = int'($urandom_range(40)) - 100;
      h = $urandom_range(20);
      r = $urandom_range(15);
      v = int'($urandom_range(60)) - 110;
      @(posedge mclk);
      {scValid, scDir, scIdx} <= {1'h1, dir, i[5:0]};
      {scLoaded, scRoc, scLast} <= {i != 2, i == 1, i == 3};
      {scSig, scExt, scH2, scReq} <= {s[9:0], x[9:0], h[9:0], r[9:0]};
      scVn <= v[9:0];
      if (!dir && h + prof > x) x = h + prof;
      if (dir && vnOn && v > x) x = v;
      m = 5 * (s - x - r);
      if (i != 1 && i != 2 && m < mn) mn = m;
    end
    code = (linePhase == `NMR_PH_DIAG || mn < -511) ? 10'h200 : mn[9:0];
    if (linePhase != `NMR_PH_SHOW) fq.push_back({dir, code});
    @(posedge mclk);
    scValid <= 1'h0;
  endtask

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  // Compares each far-end report with the oldest expected note.
  always @(posedge mclk) begin
    if (farValid === 1'h1) check({farDir, farMargin}, fq.size() ? fq.pop_front() : 32'hFFFFFFFF);
  end
  // Counts rate adaptation pulses; only downstream updates are sent.
  always @(posedge mclk) begin
    if (raReq === 1'h1) begin
      nRa++;
      check(raDir, 0);
    end
  end
  // Cuts a hung run short.
  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    void'($urandom(32'hD3103122));
    rst = 1'h1;
    {avs_read, avs_write, avs_address, avs_writedata, linePhase} = '0;
    {scValid, scDir, scIdx, scLoaded, scRoc, scLast} = '0;
    {scExt, scH2, scSig, scReq, scVn} = '0;
    prof = -100;
    repeat (4) @(posedge mclk);
    rst <= 1'h0;
    bus(0, `NMR_OFF_CAP, 0);
    check(rd[1:0], 2'h3);
    bus(0, 5'h1D, 0);
    check(rd, 0);
    bus(0, `NMR_OFF_LIM_DS, 0);
    check(rd, 32'h03D202D4);
    bus(0, `NMR_OFF_MRG_DS, 0);
    check(rd, 32'h200);
    bus(1, `NMR_OFF_LIM_US, 32'h03D202D4);
    bus(1, `NMR_OFF_IRQ_MSK, 32'hF);
    bus(1, `NMR_OFF_CTRL, 32'h0D);
    linePhase <= `NMR_PH_INIT;
    i_peer.send(0, 0, prof[9:0]);
    sweep(0, 0, cds);
    bus(0, `NMR_OFF_MRG_DS, 0);
    check(rd, {22'h0, cds});
    sweep(1, 0, c);
    bus(0, `NMR_OFF_MRG_US, 0);
    check(rd, {22'h0, c});
    bus(1, `NMR_OFF_IRQ_MSK, 32'h0);
    repeat (2) @(posedge mclk);
    check(irq, 0);
    bus(1, `NMR_OFF_IRQ_MSK, 32'hF);
    repeat (2) @(posedge mclk);
    check(irq, 1);
    bus(0, `NMR_OFF_IRQ_ST, 0);
    check(rd, 32'h3);
    repeat (2) @(posedge mclk);
    check(irq, 0);
    linePhase <= `NMR_PH_SHOW;
    fq.push_back({1'h0, cds});
    i_peer.ask(0);
    sweep(0, 1, c);
    bus(0, `NMR_OFF_MRG_DS, 0);
    check(rd, {22'h0, cds});
    bus(1, `NMR_OFF_CTRL, 32'h10D);
    sweep(0, 1, c);
    bus(0, `NMR_OFF_MRG_DS, 0);
    check(rd, 32'h200);
    bus(0, `NMR_OFF_CTRL, 0);
    check(rd, 32'h0D);
    bus(1, `NMR_OFF_CTRL, 32'h215);
    vnOn = 1;
    sweep(1, 0, c);
    bus(0, `NMR_OFF_MRG_US, 0);
    check(rd, {22'h0, c});
    i_peer.send(1, 0, 10'h34C);
    i_peer.send(1, 0, 10'h2C0);
    bus(0, `NMR_OFF_IRQ_ST, 0);
    check(rd, 32'hF);
    i_peer.send(1, 0, 10'h2C0);
    bus(0, `NMR_OFF_IRQ_ST, 0);
    check(rd, 32'h8);
    check(nRa, 2);
    linePhase <= `NMR_PH_DIAG;
    sweep(0, 0, c);
    bus(0, `NMR_OFF_MRG_DS, 0);
    check(rd, 32'h200);
    check(msgRateFast, 1);
    bus(1, `NMR_OFF_CTRL, 32'h09);
    repeat (3) @(posedge mclk);
    check(msgRateFast, 0);
    bus(1, `NMR_OFF_CTRL, 32'h3F);
    bus(0, `NMR_OFF_CTRL, 0);
    check(rd, 32'h09);
    check(fq.size(), 0);
    end_of_test();
  end
endmodule // nmr_core_tb
